// File: fpsl_cfg.svh
// timing, pattern and fault-code constants of the front-panel supervisor
`ifndef FPSL_CFG_SVH
`define FPSL_CFG_SVH

`define FPSL_CLK_MHZ          100
`define FPSL_HOLD_MS          3000
`define FPSL_HOLD_CYC         (`FPSL_HOLD_MS * `FPSL_CLK_MHZ * 1000)
`define FPSL_BLINK_HALF_MS    500
`define FPSL_BLINK_HALF_CYC   (`FPSL_BLINK_HALF_MS * `FPSL_CLK_MHZ * 1000)
`define FPSL_GAP_MS           2000
`define FPSL_GAP_TICKS        (`FPSL_GAP_MS / `FPSL_BLINK_HALF_MS)
`define FPSL_FILT_STEP_US     1000
`define FPSL_FILT_STEP_CYC    (`FPSL_FILT_STEP_US * `FPSL_CLK_MHZ)

`define FPSL_PAT_NONE         2'h0
`define FPSL_PAT_RUN          2'h1
`define FPSL_PAT_LOAD         2'h2
`define FPSL_PAT_BOTH         2'h3

`define FPSL_FLT_NONE         3'h0
`define FPSL_FLT_HWID_EMPTY   3'h2
`define FPSL_FLT_ID_CORRUPT   3'h3
`define FPSL_FLT_ID_TEXT      3'h4
`define FPSL_FLT_ID_MISSING   3'h5

`define FPSL_RUN_RST          1'b0
`define FPSL_SUPPLY_RST       1'b1

`endif

// File: fpsl_pkg.sv
// types shared by the front-panel supervisor files
`default_nettype none
package fpsl_pkg;

  typedef enum logic [1:0] {
    ST_BOOT,
    ST_IDLE,
    ST_HOLD,
    ST_WAIT
  } fpsl_state_t;

  typedef struct packed {
    logic bootable;
    logic fw_present;
    logic default_application_file;
  } fpsl_card_t;

  typedef struct packed {
    logic selftest_pass;
    logic force_en;
    logic io_only;
    logic dl_active;
    logic dl_done;
  } fpsl_sys_t;

  typedef struct packed {
    logic boot_card;
    logic fw_load;
    logic app_load;
    logic erase_all;
    logic reboot;
  } fpsl_cmd_t;

endpackage
`default_nettype wire

// File: fpsl_filter.sv
// input filter: output follows the input once it has stayed different for a strength-set time
`timescale 1ns/1ns
`default_nettype none
`include "fpsl_cfg.svh"
module fpsl_filter #(
  parameter logic [31:0] STEP_CYC = 32'(`FPSL_FILT_STEP_CYC)
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [2:0] strength,
  input  wire logic       raw,
  output var  logic       filt
);

  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic        filt_reg;
  logic        filt_next;

  // stronger filtering waits (strength+1) steps before accepting a new level
  wire [31:0] limit   = 32'(({29'h0, strength} + 32'h1) * STEP_CYC);
  wire        differ  = raw != filt_reg;
  wire        settled = differ && (cnt_reg == limit - 32'h1);

  assign cnt_next  = differ ? (settled ? 32'h0 : cnt_reg + 32'h1) : 32'h0;
  assign filt_next = settled ? raw : filt_reg;
  assign filt      = filt_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg  <= 32'h0;
      filt_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      filt_reg <= filt_next;
    end
  end

  filt_settle_a: assert property (@(posedge clk) disable iff (rst)
    (filt_reg != $past(filt_reg)) |-> ($past(cnt_reg) == $past(limit) - 32'h1) && ($past(raw) == filt_reg))
    else $error("filtered level changed before the filter time ran out");

endmodule
`default_nettype wire

// File: fpsl_top.sv
// front-panel supervisor: button hold timing, load/erase/run commands and indicator patterns
`timescale 1ns/1ns
`default_nettype none
`include "fpsl_cfg.svh"
module fpsl_top #(
  parameter logic [31:0] HOLD_CYC       = 32'(`FPSL_HOLD_CYC),
  parameter logic [31:0] BLINK_HALF_CYC = 32'(`FPSL_BLINK_HALF_CYC),
  parameter logic [31:0] FILT_STEP_CYC  = 32'(`FPSL_FILT_STEP_CYC)
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                load_btn,
  input  wire logic                runhalt_btn,
  input  wire logic [2:0]          filter_const,
  input  wire fpsl_pkg::fpsl_card_t card_i,
  input  wire fpsl_pkg::fpsl_sys_t  sys_i,
  input  wire logic [2:0]          fault_code,
  output var  fpsl_pkg::fpsl_cmd_t  cmd_o,
  output var  logic                run_mode,
  output var  logic                health_led,
  output var  logic                exec_led,
  output var  logic                supply_indicator
);

  // ---------------- filtered buttons ----------------
  logic load_f;
  logic run_f;

  fpsl_filter #(
    .STEP_CYC (FILT_STEP_CYC)
  ) u_filt_load (
    .clk      (clk),
    .rst      (rst),
    .strength (filter_const),
    .raw      (load_btn),
    .filt     (load_f)
  );

  fpsl_filter #(
    .STEP_CYC (FILT_STEP_CYC)
  ) u_filt_run (
    .clk      (clk),
    .rst      (rst),
    .strength (filter_const),
    .raw      (runhalt_btn),
    .filt     (run_f)
  );

  // ---------------- hold timing ----------------
  fpsl_pkg::fpsl_state_t state_reg;
  fpsl_pkg::fpsl_state_t state_next;
  fpsl_pkg::fpsl_cmd_t   cmd_reg;
  fpsl_pkg::fpsl_cmd_t   cmd_next;
  logic [1:0]            pat_reg;
  logic [1:0]            pat_next;
  logic [31:0]           hold_cnt_reg;
  logic [31:0]           hold_cnt_next;
  logic                  run_reg;
  logic                  run_next;
  logic                  reboot_pend_reg;
  logic                  reboot_pend_next;

  wire [1:0] pat        = {load_f, run_f};
  wire       pat_same   = pat == pat_reg;
  wire       hold_done  = hold_cnt_reg == HOLD_CYC - 32'h1;
  wire       fire       = (state_reg == fpsl_pkg::ST_HOLD) && pat_same && hold_done;
  wire       fire_load  = fire && (pat_reg == `FPSL_PAT_LOAD);
  wire       fire_run   = fire && (pat_reg == `FPSL_PAT_RUN);
  wire       fire_both  = fire && (pat_reg == `FPSL_PAT_BOTH);
  // the raw pin is used at boot: the filter has not settled yet
  wire       boot_card  = (state_reg == fpsl_pkg::ST_BOOT) && load_btn;
  wire       boot_fw    = boot_card && card_i.bootable && card_i.fw_present;
  wire       load_fw    = fire_load && card_i.fw_present;
  wire       load_app   = fire_load && !card_i.fw_present && card_i.default_application_file;

  always_comb begin
    state_next    = state_reg;
    pat_next      = pat_reg;
    hold_cnt_next = hold_cnt_reg;
    unique case (state_reg)
      fpsl_pkg::ST_BOOT: begin
        // unless the filter time is one cycle, ST_WAIT sees the filtered buttons still released and passes to ST_IDLE, so a button held from power-up counts
        state_next = fpsl_pkg::ST_WAIT;
      end
      fpsl_pkg::ST_IDLE: begin
        if (pat != `FPSL_PAT_NONE) begin
          state_next    = fpsl_pkg::ST_HOLD;
          pat_next      = pat;
          hold_cnt_next = 32'h0;
        end
      end
      fpsl_pkg::ST_HOLD: begin
        if (!pat_same) begin
          // any change of the pressed set restarts the three-second hold
          state_next    = (pat == `FPSL_PAT_NONE) ? fpsl_pkg::ST_IDLE : fpsl_pkg::ST_HOLD;
          pat_next      = pat;
          hold_cnt_next = 32'h0;
        end else if (hold_done) begin
          state_next = fpsl_pkg::ST_WAIT;
        end else begin
          hold_cnt_next = hold_cnt_reg + 32'h1;
        end
      end
      fpsl_pkg::ST_WAIT: begin
        if (pat == `FPSL_PAT_NONE) begin
          state_next = fpsl_pkg::ST_IDLE;
        end
      end
    endcase
  end

  assign cmd_next.boot_card = boot_card;
  assign cmd_next.fw_load   = boot_fw || load_fw;
  assign cmd_next.app_load  = load_app;
  assign cmd_next.erase_all = fire_both;
  assign cmd_next.reboot    = sys_i.dl_done && !reboot_pend_reg;
  assign run_next           = fire_run ? !run_reg : run_reg;
  assign reboot_pend_next   = reboot_pend_reg || sys_i.dl_done;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg       <= fpsl_pkg::ST_BOOT;
      pat_reg         <= `FPSL_PAT_NONE;
      hold_cnt_reg    <= 32'h0;
      cmd_reg         <= '0;
      run_reg         <= `FPSL_RUN_RST;
      reboot_pend_reg <= 1'b0;
    end else begin
      state_reg       <= state_next;
      pat_reg         <= pat_next;
      hold_cnt_reg    <= hold_cnt_next;
      cmd_reg         <= cmd_next;
      run_reg         <= run_next;
      reboot_pend_reg <= reboot_pend_next;
    end
  end

  // ---------------- blink time base ----------------
  logic [31:0] tick_cnt_reg;
  logic        blink_reg;

  wire tick = tick_cnt_reg == BLINK_HALF_CYC - 32'h1;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_reg <= 32'h0;
      blink_reg    <= 1'b0;
    end else begin
      tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
      blink_reg    <= tick ? !blink_reg : blink_reg;
    end
  end

  // ---------------- fault flash sequencer ----------------
  logic       gap_reg;
  logic       gap_next;
  logic [2:0] gap_cnt_reg;
  logic [2:0] gap_cnt_next;
  logic [2:0] pulse_cnt_reg;
  logic [2:0] pulse_cnt_next;
  logic       flash_on_reg;
  logic       flash_on_next;
  logic [2:0] code_reg;
  logic [2:0] code_next;

  // unknown codes do not start a pattern
  wire fault_act = (fault_code == `FPSL_FLT_HWID_EMPTY) || (fault_code == `FPSL_FLT_ID_CORRUPT) ||
                   (fault_code == `FPSL_FLT_ID_TEXT) || (fault_code == `FPSL_FLT_ID_MISSING);
  wire gap_last  = gap_cnt_reg == 3'(`FPSL_GAP_TICKS - 1);
  wire last_one  = (pulse_cnt_reg + 3'h1) == code_reg;

  always_comb begin
    gap_next       = gap_reg;
    gap_cnt_next   = gap_cnt_reg;
    pulse_cnt_next = pulse_cnt_reg;
    flash_on_next  = flash_on_reg;
    code_next      = code_reg;
    if (!fault_act) begin
      // parked so that a new fault starts its first flash on the next tick
      gap_next       = 1'b1;
      gap_cnt_next   = 3'(`FPSL_GAP_TICKS - 1);
      pulse_cnt_next = 3'h0;
      flash_on_next  = 1'b0;
      code_next      = `FPSL_FLT_NONE;
    end else if (tick) begin
      if (gap_reg) begin
        if (gap_last) begin
          // code is latched per round so a change to another active code never cuts a pattern short
          gap_next       = 1'b0;
          flash_on_next  = 1'b1;
          pulse_cnt_next = 3'h0;
          code_next      = fault_code;
        end else begin
          gap_cnt_next = gap_cnt_reg + 3'h1;
        end
      end else if (flash_on_reg) begin
        flash_on_next  = 1'b0;
        pulse_cnt_next = pulse_cnt_reg + 3'h1;
        if (last_one) begin
          gap_next     = 1'b1;
          gap_cnt_next = 3'h0;
        end
      end else begin
        flash_on_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gap_reg       <= 1'b1;
      gap_cnt_reg   <= 3'(`FPSL_GAP_TICKS - 1);
      pulse_cnt_reg <= 3'h0;
      flash_on_reg  <= 1'b0;
      code_reg      <= `FPSL_FLT_NONE;
    end else begin
      gap_reg       <= gap_next;
      gap_cnt_reg   <= gap_cnt_next;
      pulse_cnt_reg <= pulse_cnt_next;
      flash_on_reg  <= flash_on_next;
      code_reg      <= code_next;
    end
  end

  // ---------------- indicator selection ----------------
  logic health_reg;
  logic exec_reg;
  logic supply_reg;

  wire dark       = reboot_pend_reg || sys_i.dl_done;
  wire alt_mode   = sys_i.dl_active && !dark;
  wire fault_mode = fault_act && !sys_i.dl_active && !dark;
  wire norm_mode  = !fault_act && !sys_i.dl_active && !dark;
  wire health_nrm = sys_i.selftest_pass && (sys_i.force_en ? blink_reg : 1'b1);
  wire exec_nrm   = sys_i.io_only ? blink_reg : run_reg;
  wire health_nxt = alt_mode ? blink_reg : fault_mode ? flash_on_reg : norm_mode && health_nrm;
  wire exec_nxt   = alt_mode ? !blink_reg : fault_mode ? flash_on_reg : norm_mode && exec_nrm;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      health_reg <= 1'b0;
      exec_reg   <= 1'b0;
      supply_reg <= `FPSL_SUPPLY_RST;
    end else begin
      health_reg <= health_nxt;
      exec_reg   <= exec_nxt;
      supply_reg <= `FPSL_SUPPLY_RST;
    end
  end

  assign cmd_o            = cmd_reg;
  assign run_mode         = run_reg;
  assign health_led       = health_reg;
  assign exec_led         = exec_reg;
  assign supply_indicator = supply_reg;

  // ---------------- checks ----------------
  boot_card_a: assert property (@(posedge clk) disable iff (rst)
    (state_reg == fpsl_pkg::ST_BOOT) |=> (cmd_o.boot_card == $past(load_btn)))
    else $error("card boot not taken from load button at power-up");

  boot_fw_a: assert property (@(posedge clk) disable iff (rst)
    (state_reg == fpsl_pkg::ST_BOOT && load_btn && card_i.bootable && card_i.fw_present) |=> cmd_o.fw_load)
    else $error("bootable card with firmware did not start a firmware load");

  hold_time_a: assert property (@(posedge clk) disable iff (rst)
    (cmd_o.app_load || cmd_o.erase_all) |-> ($past(hold_cnt_reg) == HOLD_CYC - 32'h1))
    else $error("button action fired before the full hold time");

  app_pick_a: assert property (@(posedge clk) disable iff (rst)
    cmd_o.app_load |-> $past(!card_i.fw_present && card_i.default_application_file && pat_reg == `FPSL_PAT_LOAD))
    else $error("application load chosen while firmware present or file missing");

  fw_pick_a: assert property (@(posedge clk) disable iff (rst)
    (fire_load && card_i.fw_present) |=> (cmd_o.fw_load && !cmd_o.app_load))
    else $error("firmware on card did not take priority over application");

  run_tog_a: assert property (@(posedge clk) disable iff (rst)
    (run_mode != $past(run_mode)) |-> $past(fire_run))
    else $error("run mode changed without a full run-halt hold");

  erase_a: assert property (@(posedge clk) disable iff (rst)
    cmd_o.erase_all |-> (!cmd_o.fw_load && !cmd_o.app_load && run_mode == $past(run_mode)))
    else $error("erase combined with a single-button action");

  alt_flash_a: assert property (@(posedge clk) disable iff (rst)
    (sys_i.dl_active && !dark) |=> (health_led != exec_led))
    else $error("indicators not alternating during download");

  done_dark_a: assert property (@(posedge clk) disable iff (rst)
    (sys_i.dl_done && !reboot_pend_reg) |=> cmd_o.reboot && !health_led && !exec_led
      ##1 (!health_led && !exec_led && !cmd_o.reboot)[*3])
    else $error("indicators not dark or reboot missing after download");

  fault_gap_a: assert property (@(posedge clk) disable iff (rst)
    (fault_mode && gap_reg) |=> (!health_led && !exec_led))
    else $error("indicator lit during the fault pause");

  fault_same_a: assert property (@(posedge clk) disable iff (rst)
    fault_mode |=> (health_led == exec_led))
    else $error("fault flashes not together on both indicators");

  flash_count_a: assert property (@(posedge clk) disable iff (rst)
    (gap_reg && !$past(gap_reg) && $past(fault_act)) |-> (pulse_cnt_reg == code_reg))
    else $error("fault pattern ended with the wrong number of flashes");

  health_off_a: assert property (@(posedge clk) disable iff (rst)
    (norm_mode && !sys_i.selftest_pass) |=> !health_led)
    else $error("health indicator lit after self-test failure");

  exec_run_a: assert property (@(posedge clk) disable iff (rst)
    (norm_mode && !sys_i.io_only) |=> (exec_led == $past(run_reg)))
    else $error("execution indicator does not follow run mode");

endmodule
`default_nettype wire

// File: fpsl_panel_model.sv
// panel model: operator buttons, filter setting, card status, system status and fault source
`timescale 1ns/1ns
`default_nettype none
module fpsl_panel_model (
  input  wire logic                 press_load,
  input  wire logic                 press_run,
  input  wire logic [2:0]           fconst_req,
  input  wire fpsl_pkg::fpsl_card_t card_req,
  input  wire fpsl_pkg::fpsl_sys_t  sys_req,
  input  wire logic [2:0]           fault_req,
  output var  logic                 load_btn,
  output var  logic                 runhalt_btn,
  output var  logic [2:0]           filter_const,
  output var  fpsl_pkg::fpsl_card_t card_o,
  output var  fpsl_pkg::fpsl_sys_t  sys_o,
  output var  logic [2:0]           fault_code
);
  // clean contacts: what the operator, the card and the system ask for reaches the pins unchanged,
  // so every hold and filter time seen by the bench is the block's own
  assign load_btn     = press_load;
  assign runhalt_btn  = press_run;
  assign filter_const = fconst_req;
  assign card_o       = card_req;
  assign sys_o        = sys_req;
  assign fault_code   = fault_req;
endmodule
`default_nettype wire

// File: testbench.sv
// self-checking bench for the front-panel supervisor
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int HOLD = 20;
  localparam int HALF = 4;
  localparam int STEP = 2;
  logic                 clk;
  logic                 rst;
  wire logic            load_btn;
  wire logic            runhalt_btn;
  wire logic [2:0]      filter_const;
  wire logic [2:0]      fault_code;
  wire fpsl_pkg::fpsl_card_t card;
  wire fpsl_pkg::fpsl_sys_t  sys;
  wire fpsl_pkg::fpsl_cmd_t  cmd;
  wire logic            run_mode;
  wire logic            health_led;
  wire logic            exec_led;
  wire logic            supply_indicator;
  wire logic [5:0]      obs = {cmd, run_mode};
  int                   n_errors;
  int                   checks_done;
  int                   n0;
  int                   n1;
  int                   n7;
  logic                 press_load;
  logic                 press_run;
  logic [2:0]           fconst_req;
  fpsl_pkg::fpsl_card_t card_req;
  fpsl_pkg::fpsl_sys_t  sys_req;
  logic [2:0]           fault_req;

  fpsl_top #(.HOLD_CYC(32'(HOLD)), .BLINK_HALF_CYC(32'(HALF)), .FILT_STEP_CYC(32'(STEP))) dut_u (
    .clk(clk), .rst(rst), .load_btn(load_btn), .runhalt_btn(runhalt_btn),
    .filter_const(filter_const), .card_i(card), .sys_i(sys), .fault_code(fault_code),
    .cmd_o(cmd), .run_mode(run_mode), .health_led(health_led), .exec_led(exec_led),
    .supply_indicator(supply_indicator)
  );
  fpsl_panel_model pm_u (
    .press_load(press_load), .press_run(press_run), .fconst_req(fconst_req), .card_req(card_req),
    .sys_req(sys_req), .fault_req(fault_req),
    .load_btn(load_btn), .runhalt_btn(runhalt_btn), .filter_const(filter_const),
    .card_o(card), .sys_o(sys), .fault_code(fault_code)
  );

  always #5 clk = ~clk;

  // every change lands on a falling edge, well away from the sampling edge
  task automatic btn(input logic l, input logic r);
    @(negedge clk);
    press_load = l;
    press_run = r;
  endtask
  task automatic fconst(input logic [2:0] v);
    @(negedge clk);
    fconst_req = v;
  endtask
  task automatic set_card(input logic [2:0] v);
    @(negedge clk);
    card_req = v;
  endtask
  task automatic set_sys(input logic [4:0] v);
    @(negedge clk);
    sys_req = v;
  endtask
  task automatic fault(input logic [2:0] v);
    @(negedge clk);
    fault_req = v;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic do_reset;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
  endtask
  // bounded wait for any masked observed bit to change
  task automatic wait_chg(input logic [5:0] m, output int n);
    logic [5:0] s;
    s = obs & m;
    n = 0;
    while ((obs & m) === s && n < 400) begin
      @(negedge clk);
      n++;
    end
    if (n >= 400) begin
      chk(32'h0, 32'h1);
      close_out;
    end
  endtask
  // skips the settling cycles so only the steady pattern is counted
  task automatic tog(input int cyc, output int th, output int te, output int nq);
    logic ph;
    logic pe;
    th = 0;
    te = 0;
    nq = 0;
    repeat (2) @(negedge clk);
    repeat (cyc) begin
      ph = health_led;
      pe = exec_led;
      @(negedge clk);
      th += int'(health_led !== ph);
      te += int'(exec_led !== pe);
      nq += int'(health_led !== exec_led);
    end
  endtask

  task automatic t_boot;
    for (int b = 1; b >= 0; b--) begin
      set_card(b[0] ? 3'h6 : 3'h2);
      btn(1'b1, 1'b0);
      do_reset;
      @(negedge clk);
      chk({cmd.boot_card, cmd.fw_load}, {1'b1, b[0]});
      @(negedge clk);
      chk(cmd, 5'h00);
      btn(1'b0, 1'b0);
    end
  endtask
  task automatic t_load(input logic [2:0] fc, input logic [2:0] c, input logic [4:0] m, output int n);
    fconst(fc);
    set_card(c);
    repeat (40) @(negedge clk);
    btn(1'b1, 1'b0);
    wait_chg({m, 1'b0}, n);
    chk(cmd, m);
    chk(n >= HOLD + (fc + 1) * STEP && n <= HOLD + (fc + 1) * STEP + 4, 1'b1);
    btn(1'b0, 1'b0);
    repeat (40) @(negedge clk);
  endtask
  // a press one cycle short of the hold, then a long press with nothing loadable
  task automatic t_refuse;
    logic [4:0] seen;
    seen = 5'h00;
    set_card(3'h6);
    btn(1'b1, 1'b0);
    repeat (HOLD - 1) begin
      @(negedge clk);
      seen |= cmd;
    end
    // released one edge before the hold would complete, with firmware still on the card
    btn(1'b0, 1'b0);
    repeat (10) begin
      @(negedge clk);
      seen |= cmd;
    end
    set_card(3'h0);
    btn(1'b1, 1'b0);
    repeat (60) begin
      @(negedge clk);
      seen |= cmd;
    end
    btn(1'b0, 1'b0);
    chk(seen, 5'h00);
  endtask
  task automatic t_run;
    int n;
    chk(run_mode, 1'b0);
    for (int k = 0; k < 2; k++) begin
      btn(1'b0, 1'b1);
      wait_chg(6'h01, n);
      chk({run_mode, cmd}, {k == 0, 5'h00});
      chk(n >= HOLD + STEP && n <= HOLD + STEP + 4, 1'b1);
      btn(1'b0, 1'b0);
      repeat (10) @(negedge clk);
      chk(exec_led, k == 0);
    end
  endtask
  task automatic t_erase;
    int n;
    logic r;
    btn(1'b0, 1'b1);
    wait_chg(6'h01, n);
    btn(1'b0, 1'b0);
    repeat (10) @(negedge clk);
    r = run_mode;
    btn(1'b1, 1'b1);
    wait_chg(6'h04, n);
    chk({cmd, run_mode}, {5'h02, r});
    btn(1'b0, 1'b0);
    repeat (40) @(negedge clk);
  endtask
  task automatic t_normal;
    int th;
    int te;
    int nq;
    set_sys(5'h00);
    tog(16, th, te, nq);
    chk({health_led, supply_indicator}, 2'h1);
    fault(3'h6);
    set_sys(5'h10);
    tog(16, th, te, nq);
    chk({health_led, th[7:0]}, 9'h100);
    set_sys(5'h18);
    tog(16, th, te, nq);
    chk(th, 4);
    set_sys(5'h14);
    tog(16, th, te, nq);
    chk({health_led, th[7:0], te[7:0]}, 17'h10004);
    fault(3'h0);
  endtask
  task automatic t_dl;
    int th;
    int te;
    int nq;
    set_sys(5'h12);
    tog(20, th, te, nq);
    chk({nq[7:0], th[7:0]}, 16'h1405);
    set_sys(5'h13);
    @(negedge clk);
    chk({cmd, health_led, exec_led}, 7'h04);
    tog(20, th, te, nq);
    chk({cmd, health_led, exec_led, th[3:0], te[3:0]}, 15'h0000);
    set_sys(5'h00);
  endtask
  // waits for one full gap, then counts flashes up to the next gap
  task automatic t_fault(input logic [2:0] code);
    int dark;
    int rises;
    int ph;
    int nq;
    logic prev;
    dark = 0;
    rises = 0;
    ph = 0;
    nq = 0;
    prev = 1'b0;
    fault(code);
    for (int i = 0; i < 400 && ph < 2; i++) begin
      @(negedge clk);
      nq += int'(health_led !== exec_led);
      if (health_led === 1'b1) begin
        rises += int'(!prev && ph == 1);
        dark = 0;
      end else begin
        dark++;
      end
      if (dark == 12 && (ph == 0 || rises > 0)) ph++;
      prev = health_led;
    end
    chk({ph[3:0], rises[3:0]}, {4'h2, 1'b0, code});
    chk(nq, 0);
    fault(3'h0);
  endtask

  initial begin
    n_errors = 0;
    checks_done = 0;
    clk = 1'b0;
    rst = 1'b1;
    {press_load, press_run, fconst_req, card_req, sys_req, fault_req} = 16'h0000;
    t_boot;
    do_reset;
    // firmware and the default file together: firmware must win
    t_load(3'h0, 3'h7, 5'h08, n0);
    t_load(3'h0, 3'h1, 5'h04, n1);
    t_load(3'h7, 3'h2, 5'h08, n7);
    chk(32'(n7 - n0), 32'(7 * STEP));
    fconst(3'h0);
    t_refuse;
    do_reset;
    t_run;
    t_erase;
    do_reset;
    t_normal;
    for (int c = 2; c <= 5; c++) t_fault(3'(c));
    t_dl;
    close_out;
  end
endmodule
`default_nettype wire
